// ===== design/instr_operand_decoder.sv
/*
 * decoder for processor-control opcodes, interrupt return, bounds check
 * and software interrupt, with cycle costs and the operand address.
 * assumes fetch presents one byte per i_byte_valid in program order.
 */
`timescale 1ns/1ps
module instr_operand_decoder (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_arst_n,
	input  wire logic                      i_byte_valid,
	input  wire logic [7:0]                i_byte,
	input  wire logic                      i_size_bit,
	input  wire logic [1:0]                i_mem_xfers,
	input  wire logic                      i_string_dst,
	input  wire instr_dec_pkg::addr_regs_t i_regs,
	output logic                           o_done,
	output instr_dec_pkg::op_kind_t        o_kind,
	output logic [7:0]                     o_cycles,
	output logic [7:0]                     o_cycles_max,
	output logic                           o_op_valid,
	output instr_dec_pkg::operand_t        o_operand,
	output logic                           o_lock
);
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_MODRM  = 3'b001,
		ST_DISP_L = 3'b010,
		ST_DISP_H = 3'b011,
		ST_TYPE   = 3'b100
	} state_t;

	state_t                  state_ff, nxt_state;
	logic [7:0]              modrm_ff, nxt_modrm;
	logic [7:0]              dlo_ff, nxt_dlo;
	logic                    ovr_v_ff, nxt_ovr_v;
	instr_dec_pkg::seg_t     ovr_seg_ff, nxt_ovr_seg;
	logic                    lock_ff, nxt_lock;
	logic                    done_ff, nxt_done;
	instr_dec_pkg::op_kind_t kind_ff, nxt_kind;
	logic [7:0]              cyc_ff, nxt_cyc;
	logic [7:0]              cycmax_ff, nxt_cycmax;
	logic                    opv_ff, nxt_opv;
	instr_dec_pkg::operand_t opnd_ff, nxt_opnd;
	instr_dec_pkg::operand_t ea_res;
	logic [7:0]              ea_lo, ea_hi;
	logic [7:0]              word_extra;
	logic                    op_take;

	// word cost: four cycles per memory transfer
	assign word_extra = i_size_bit
	                  ? 8'(i_mem_xfers) * instr_dec_pkg::CYC_WORD_XFER
	                  : 8'h00; // see RL7

	// low byte is the incoming byte in DISP_L, stored once DISP_H
	assign ea_lo = (state_ff == ST_DISP_H) ? dlo_ff : i_byte;
	assign ea_hi = i_byte;

	ea_unit u_ea (
		.i_size_bit  (i_size_bit),
		.i_modrm     (modrm_ff),
		.i_disp_lo   (ea_lo),
		.i_disp_hi   (ea_hi),
		.i_regs      (i_regs),
		.i_ovr_valid (ovr_v_ff),
		.i_ovr_seg   (ovr_seg_ff),
		.i_string_dst(i_string_dst),
		.o_op        (ea_res)
	);

	// sequencing and decode; one completion pulse per instruction
	always_comb begin
		nxt_state   = state_ff;
		nxt_modrm   = modrm_ff;
		nxt_dlo     = dlo_ff;
		nxt_ovr_v   = ovr_v_ff;
		nxt_ovr_seg = ovr_seg_ff;
		nxt_lock    = lock_ff;
		nxt_done    = 1'b0;
		nxt_kind    = kind_ff;
		nxt_cyc     = cyc_ff;
		nxt_cycmax  = cycmax_ff;
		nxt_opv     = 1'b0;
		nxt_opnd    = opnd_ff;
		if (i_byte_valid) begin
			unique case (state_ff)
				ST_OPCODE: begin
					nxt_done = 1'b1;
					nxt_cyc  = instr_dec_pkg::CYC_CTRL;
					nxt_cycmax = instr_dec_pkg::CYC_CTRL;
					if ((i_byte & instr_dec_pkg::SEG_PFX_MASK)
					    == instr_dec_pkg::SEG_PFX_VAL) begin
						// prefix held until the instruction ends
						nxt_done    = 1'b0;
						nxt_ovr_v   = 1'b1; // see RL14
						nxt_ovr_seg = instr_dec_pkg::seg_t'(i_byte[4:3]);
					end else begin
						unique case (i_byte)
							instr_dec_pkg::OP_CARRY_CLEAR:
								nxt_kind = instr_dec_pkg::K_CARRY_CLR; // see RL1
							instr_dec_pkg::OP_CARRY_FLIP:
								nxt_kind = instr_dec_pkg::K_CARRY_FLP; // see RL1
							instr_dec_pkg::OP_CARRY_SET:
								nxt_kind = instr_dec_pkg::K_CARRY_SET; // see RL1
							instr_dec_pkg::OP_DIR_CLEAR:
								nxt_kind = instr_dec_pkg::K_DIR_CLR; // see RL2
							instr_dec_pkg::OP_DIR_SET:
								nxt_kind = instr_dec_pkg::K_DIR_SET; // see RL2
							instr_dec_pkg::OP_INTR_CLEAR:
								nxt_kind = instr_dec_pkg::K_INTR_CLR; // see RL3
							instr_dec_pkg::OP_INTR_SET:
								nxt_kind = instr_dec_pkg::K_INTR_SET; // see RL3
							instr_dec_pkg::OP_HALT:
								nxt_kind = instr_dec_pkg::K_HALT; // see RL3
							instr_dec_pkg::OP_LOCK: begin
								nxt_kind = instr_dec_pkg::K_LOCK; // see RL4
								nxt_lock = 1'b1;
							end
							instr_dec_pkg::OP_NOP: begin
								nxt_kind = instr_dec_pkg::K_NOP; // see RL4
								nxt_cyc  = instr_dec_pkg::CYC_NOP;
								nxt_cycmax = instr_dec_pkg::CYC_NOP;
							end
							instr_dec_pkg::OP_INTR_RETURN: begin
								nxt_kind = instr_dec_pkg::K_INTR_RET; // see RL5
								nxt_cyc  = instr_dec_pkg::CYC_INTR_RET;
								nxt_cycmax = instr_dec_pkg::CYC_INTR_RET;
							end
							instr_dec_pkg::OP_BOUND: begin
								nxt_done  = 1'b0; // see RL6
								nxt_kind  = instr_dec_pkg::K_BOUND;
								nxt_state = ST_MODRM;
							end
							instr_dec_pkg::OP_SOFT_INTR: begin
								nxt_done  = 1'b0; // see RL18
								nxt_kind  = instr_dec_pkg::K_SOFT_INTR;
								nxt_state = ST_TYPE;
							end
							default: begin
								// outside this decoder's share: no completion, kind set to K_NONE
								nxt_done = 1'b0;
								nxt_kind = instr_dec_pkg::K_NONE;
							end
						endcase
						// prefixes apply to the next instruction only
						if (nxt_done && i_byte != instr_dec_pkg::OP_LOCK) begin
							nxt_ovr_v = 1'b0;
							nxt_lock  = 1'b0;
						end
					end
				end
				ST_TYPE: begin
					nxt_done   = 1'b1;
					nxt_cyc    = instr_dec_pkg::CYC_SOFT_INTR; // see RL18
					nxt_cycmax = instr_dec_pkg::CYC_SOFT_INTR;
					nxt_state  = ST_OPCODE;
					nxt_ovr_v  = 1'b0;
					nxt_lock   = 1'b0;
				end
				ST_MODRM: begin
					nxt_modrm = i_byte;
					// displacement comes straight after this byte
					if ((i_byte[7:6] == instr_dec_pkg::FORM_DISP8)
					    || (i_byte[7:6] == instr_dec_pkg::FORM_DISP16)
					    || (i_byte[7:6] == instr_dec_pkg::FORM_NO_DISP
					        && i_byte[2:0] == instr_dec_pkg::SEL_DIRECT))
						nxt_state = ST_DISP_L; // see RL12
					else
						nxt_state = ST_DISP_H;
				end
				ST_DISP_L: begin
					nxt_dlo = i_byte;
					if (ea_res.disp_bytes == 2'h2)
						nxt_state = ST_DISP_H;
				end
				ST_DISP_H: begin
					nxt_state = ST_OPCODE;
				end
				default: nxt_state = ST_OPCODE;
			endcase
		end
		// operand complete: finished form without needing another byte
		if ((state_ff == ST_DISP_L && i_byte_valid
		     && ea_res.disp_bytes == 2'h1)
		    || (state_ff == ST_DISP_H
		        && (ea_res.disp_bytes == 2'h0 || i_byte_valid))) begin
			nxt_state  = ST_OPCODE;
			nxt_opv    = 1'b1;
			nxt_opnd   = ea_res;
			nxt_done   = 1'b1;
			// address time is inside the quoted range
			nxt_cyc    = instr_dec_pkg::CYC_BOUND_MIN + word_extra; // see RL13
			nxt_cycmax = instr_dec_pkg::CYC_BOUND_MAX + word_extra; // see RL6
			nxt_ovr_v  = 1'b0;
			nxt_lock   = 1'b0;
		end
	end

	// registers only
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff   <= ST_OPCODE;
			modrm_ff   <= 8'h00;
			dlo_ff     <= 8'h00;
			ovr_v_ff   <= 1'b0;
			ovr_seg_ff <= instr_dec_pkg::SEG_EXTRA;
			lock_ff    <= 1'b0;
			done_ff    <= 1'b0;
			kind_ff    <= instr_dec_pkg::K_NONE;
			cyc_ff     <= 8'h00;
			cycmax_ff  <= 8'h00;
			opv_ff     <= 1'b0;
			opnd_ff    <= '0;
		end else begin
			state_ff   <= nxt_state;
			modrm_ff   <= nxt_modrm;
			dlo_ff     <= nxt_dlo;
			ovr_v_ff   <= nxt_ovr_v;
			ovr_seg_ff <= nxt_ovr_seg;
			lock_ff    <= nxt_lock;
			done_ff    <= nxt_done;
			kind_ff    <= nxt_kind;
			cyc_ff     <= nxt_cyc;
			cycmax_ff  <= nxt_cycmax;
			opv_ff     <= nxt_opv;
			opnd_ff    <= nxt_opnd;
		end
	end

	assign o_done       = done_ff;
	assign o_kind       = kind_ff;
	assign o_cycles     = cyc_ff;
	assign o_cycles_max = cycmax_ff;
	assign o_op_valid   = opv_ff;
	assign o_operand    = opnd_ff;
	assign o_lock       = lock_ff;

	// opcode byte taken at this edge; shortens the checks below
	assign op_take = i_byte_valid && (state_ff == ST_OPCODE);

	AST_CTRL_TWO: assert property ( // see RL1
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(op_take && i_byte == instr_dec_pkg::OP_CARRY_SET)
		|=> (o_done && o_cycles == 8'h02
		     && o_kind == instr_dec_pkg::K_CARRY_SET))
		else $error("carry set not two cycles");

	AST_DIR_SET: assert property ( // see RL2
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(op_take && i_byte == instr_dec_pkg::OP_DIR_SET)
		|=> (o_kind == instr_dec_pkg::K_DIR_SET && o_cycles == 8'h02))
		else $error("direction set decode wrong");

	AST_HALT: assert property ( // see RL3
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(op_take && i_byte == instr_dec_pkg::OP_HALT)
		|=> (o_done && o_kind == instr_dec_pkg::K_HALT))
		else $error("halt decode wrong");

	AST_NOP_THREE: assert property ( // see RL4
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(op_take && i_byte == instr_dec_pkg::OP_NOP)
		|=> (o_cycles == 8'h03))
		else $error("no-op cost wrong");

	AST_LOCK: assert property ( // see RL4
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(op_take && i_byte == instr_dec_pkg::OP_LOCK)
		|=> (o_done && o_lock && o_cycles == 8'h02
		     && o_kind == instr_dec_pkg::K_LOCK))
		else $error("lock prefix decode wrong");

	AST_INTR_RETURN_OP: assert property ( // see RL5
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(op_take && i_byte == instr_dec_pkg::OP_INTR_RETURN)
		|=> (o_cycles == 8'h1C && o_kind == instr_dec_pkg::K_INTR_RET))
		else $error("interrupt return cost wrong");

	AST_BOUND_RANGE: assert property ( // see RL6
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(o_op_valid && !i_size_bit && $past(i_size_bit) == 1'b0
		 && $past(i_mem_xfers) == 2'h0)
		|-> (o_cycles == 8'h21 && o_cycles_max == 8'h23))
		else $error("bounds check cost wrong");

	AST_WORD_COST: assert property ( // see RL7
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(o_op_valid && $past(i_size_bit) == 1'b1)
		|-> (o_cycles == 8'h21 + 8'($past(i_mem_xfers)) * 8'h04
		     && o_cycles_max == 8'h23 + 8'($past(i_mem_xfers)) * 8'h04))
		else $error("word transfer cost wrong");

	AST_DIRECT: assert property ( // see RL11
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(o_op_valid && o_operand.disp_bytes == 2'h2 && !o_operand.is_reg
		 && $past(modrm_ff[7:6]) == 2'h0)
		|-> (o_operand.effective_address
		     == {$past(i_byte), $past(dlo_ff)}))
		else $error("direct address wrong");

	AST_STRING_SEG: assert property ( // see RL17
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(o_op_valid && $past(i_string_dst) == 1'b1)
		|-> (o_operand.seg == instr_dec_pkg::SEG_EXTRA))
		else $error("string destination not in extra segment");

	AST_SOFT_INT: assert property ( // see RL18
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(op_take && i_byte == instr_dec_pkg::OP_SOFT_INTR)
		##1 (i_byte_valid && state_ff == ST_TYPE)
		|=> (o_done && o_cycles == 8'h2F))
		else $error("software interrupt cost wrong");

	AST_REG_FORM: assert property ( // see RL8
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(o_op_valid && $past(modrm_ff[7:6]) == 2'h3)
		|-> (o_operand.is_reg && o_operand.effective_address == 16'h0000))
		else $error("register form not flagged");
endmodule

// ===== design/instr_dec_pkg.sv
/*
 * constants and carrier types for the instruction tail decoder.
 * assumes a single 250 MHz core clock and byte-wide fetch.
 */
// Functional notes
// [RL1] carry clear, flip and set opcodes decode, two cycles each.
// [RL2] direction clear and set opcodes decode, two cycles each.
// [RL3] interrupt clear/set and halt opcodes decode, two cycles each.
// [RL4] lock prefix takes two cycles; no-operation takes three.
// [RL5] interrupt return decodes, 28 cycles on both bus widths.
// [RL6] bounds check with addressing byte takes 33 to 35 cycles.
// [RL7] word operations add four cycles per memory transfer.
// [RL8] form 11 makes the operand select field a register code.
// [RL9] form 00 no offset, 01 sign-extended byte, 10 full word.
// [RL10] operand select picks the register sum, plus offset.
// [RL11] form 00 with select 110 is a direct 16-bit address.
// [RL12] displacement bytes follow the second byte, before immediates.
// [RL13] address calculation costs four cycles, inside quoted times.
// [RL14] prefix 001rr110 overrides segment: extra, code, stack, data.
// [RL15] register codes map to word or byte registers by size bit.
// [RL16] operands addressed through frame pointer default to stack.
// [RL17] string destinations always use extra segment, no override.
// [RL18] software interrupt with type byte takes 47 cycles.
// [RL19] other memory operands default to data segment unless overridden.
package instr_dec_pkg;
	localparam logic [7:0] OP_CARRY_CLEAR = 8'hF8;
	localparam logic [7:0] OP_CARRY_FLIP  = 8'hF5;
	localparam logic [7:0] OP_CARRY_SET   = 8'hF9;
	localparam logic [7:0] OP_DIR_CLEAR   = 8'hFC;
	localparam logic [7:0] OP_DIR_SET     = 8'hFD;
	localparam logic [7:0] OP_INTR_CLEAR  = 8'hFA;
	localparam logic [7:0] OP_INTR_SET    = 8'hFB;
	localparam logic [7:0] OP_HALT        = 8'hF4;
	localparam logic [7:0] OP_LOCK        = 8'hF0;
	localparam logic [7:0] OP_NOP         = 8'h90;
	localparam logic [7:0] OP_INTR_RETURN = 8'hCF;
	localparam logic [7:0] OP_BOUND       = 8'h62;
	localparam logic [7:0] OP_SOFT_INTR   = 8'hCD;
	localparam logic [7:0] SEG_PFX_MASK   = 8'hE7;
	localparam logic [7:0] SEG_PFX_VAL    = 8'h26;

	localparam logic [7:0] CYC_CTRL       = 8'h02;
	localparam logic [7:0] CYC_NOP        = 8'h03;
	localparam logic [7:0] CYC_INTR_RET   = 8'h1C;
	localparam logic [7:0] CYC_BOUND_MIN  = 8'h21;
	localparam logic [7:0] CYC_BOUND_MAX  = 8'h23;
	localparam logic [7:0] CYC_SOFT_INTR  = 8'h2F;
	localparam logic [7:0] CYC_WORD_XFER  = 8'h04;
	localparam logic [7:0] CYC_EA         = 8'h04;

	localparam logic [1:0] FORM_NO_DISP   = 2'h0;
	localparam logic [1:0] FORM_DISP8     = 2'h1;
	localparam logic [1:0] FORM_DISP16    = 2'h2;
	localparam logic [1:0] FORM_REG       = 2'h3;
	localparam logic [2:0] SEL_DIRECT     = 3'h6;

	typedef enum logic [1:0] {
		SEG_EXTRA = 2'b00,
		SEG_CODE  = 2'b01,
		SEG_STACK = 2'b10,
		SEG_DATA  = 2'b11
	} seg_t;

	typedef enum logic [3:0] {
		K_NONE   = 4'b0000,
		K_CARRY_CLR = 4'b0001,
		K_CARRY_FLP = 4'b0010,
		K_CARRY_SET = 4'b0011,
		K_DIR_CLR   = 4'b0100,
		K_DIR_SET   = 4'b0101,
		K_INTR_CLR  = 4'b0110,
		K_INTR_SET  = 4'b0111,
		K_HALT      = 4'b1000,
		K_LOCK      = 4'b1001,
		K_NOP       = 4'b1010,
		K_INTR_RET  = 4'b1011,
		K_BOUND     = 4'b1100,
		K_SOFT_INTR = 4'b1101
	} op_kind_t;

	// register file image the address adder reads
	typedef struct packed {
		logic [15:0] base_word;
		logic [15:0] frame_ptr;
		logic [15:0] source_index_ptr;
		logic [15:0] dest_index_ptr;
	} addr_regs_t;

	// operand decode result
	typedef struct packed {
		logic        is_reg;
		logic [3:0]  reg_id;   // {size_bit, code}
		logic [15:0] effective_address;
		seg_t        seg;
		logic [1:0]  disp_bytes;
	} operand_t;
endpackage

// ===== design/ea_unit.sv
/*
 * effective address and segment selection for one addressing byte.
 * assumes displacement bytes and register values are already stable.
 */
`timescale 1ns/1ps
module ea_unit (
	input  wire logic                      i_size_bit,
	input  wire logic [7:0]                i_modrm,
	input  wire logic [7:0]                i_disp_lo,
	input  wire logic [7:0]                i_disp_hi,
	input  wire instr_dec_pkg::addr_regs_t i_regs,
	input  wire logic                      i_ovr_valid,
	input  wire instr_dec_pkg::seg_t       i_ovr_seg,
	input  wire logic                      i_string_dst,
	output instr_dec_pkg::operand_t        o_op
);
	logic [1:0]  form;
	logic [2:0]  sel;
	logic [15:0] disp;
	logic [15:0] base_sum;
	logic        uses_frame;
	logic [1:0]  disp_bytes;

	assign form = i_modrm[7:6];
	assign sel  = i_modrm[2:0];

	// displacement by form; bytes sit right after the addressing byte
	always_comb begin
		disp = 16'h0000;
		disp_bytes = 2'h0;
		unique case (form)
			instr_dec_pkg::FORM_NO_DISP: begin // see RL9
				disp = 16'h0000;
				if (sel == instr_dec_pkg::SEL_DIRECT) begin // see RL11
					disp = {i_disp_hi, i_disp_lo};
					disp_bytes = 2'h2;
				end
			end
			instr_dec_pkg::FORM_DISP8: begin // see RL9 RL12
				disp = {{8{i_disp_lo[7]}}, i_disp_lo};
				disp_bytes = 2'h1;
			end
			instr_dec_pkg::FORM_DISP16: begin // see RL9 RL12
				disp = {i_disp_hi, i_disp_lo};
				disp_bytes = 2'h2;
			end
			instr_dec_pkg::FORM_REG: begin
				disp = 16'h0000;
			end
		endcase
	end

	// register sum by operand select
	always_comb begin
		uses_frame = 1'b0;
		unique case (sel) // see RL10
			3'h0: base_sum = i_regs.base_word + i_regs.source_index_ptr;
			3'h1: base_sum = i_regs.base_word + i_regs.dest_index_ptr;
			3'h2: begin
				base_sum = i_regs.frame_ptr + i_regs.source_index_ptr;
				uses_frame = 1'b1;
			end
			3'h3: begin
				base_sum = i_regs.frame_ptr + i_regs.dest_index_ptr;
				uses_frame = 1'b1;
			end
			3'h4: base_sum = i_regs.source_index_ptr;
			3'h5: base_sum = i_regs.dest_index_ptr;
			3'h6: begin
				base_sum = i_regs.frame_ptr;
				uses_frame = 1'b1;
			end
			3'h7: base_sum = i_regs.base_word;
		endcase
		// direct form has no register part at all
		if (form == instr_dec_pkg::FORM_NO_DISP
		    && sel == instr_dec_pkg::SEL_DIRECT) begin // see RL11
			base_sum = 16'h0000;
			uses_frame = 1'b0;
		end
	end

	// result and segment; string destination beats any prefix
	always_comb begin
		o_op.is_reg = (form == instr_dec_pkg::FORM_REG); // see RL8
		o_op.reg_id = {i_size_bit, sel}; // see RL15
		o_op.disp_bytes = disp_bytes;
		o_op.effective_address = o_op.is_reg ? 16'h0000
		                                     : base_sum + disp;
		if (i_string_dst)
			o_op.seg = instr_dec_pkg::SEG_EXTRA; // see RL17
		else if (i_ovr_valid)
			o_op.seg = i_ovr_seg; // see RL14
		else if (uses_frame && !o_op.is_reg)
			o_op.seg = instr_dec_pkg::SEG_STACK; // see RL16
		else
			o_op.seg = instr_dec_pkg::SEG_DATA; // see RL19
	end
endmodule

// ===== tb/test_instr_operand_decoder.sv
/*
 * self-checking bench for the instruction tail decoder.
 * assumes the decoder's own assertions sit in the design files.
 */
`timescale 1ns/1ps
module test_instr_operand_decoder;
	typedef struct packed {
		instr_dec_pkg::op_kind_t kind;
		logic [7:0]              cyc;
		logic [7:0]              cmax;
		logic                    has_op;
		instr_dec_pkg::operand_t op;
		instr_dec_pkg::operand_t mask;
	} exp_t;

	logic                      i_clk_sys;
	logic                      i_arst_n;
	logic                      i_byte_valid;
	logic [7:0]                i_byte;
	logic                      i_size_bit;
	logic [1:0]                i_mem_xfers;
	logic                      i_string_dst;
	instr_dec_pkg::addr_regs_t i_regs;
	logic                      o_done;
	instr_dec_pkg::op_kind_t   o_kind;
	logic [7:0]                o_cycles;
	logic [7:0]                o_cycles_max;
	logic                      o_op_valid;
	instr_dec_pkg::operand_t   o_operand;
	logic                      o_lock;
	exp_t                      exp_q[$];
	int                        num_errors;
	int                        checks_done;
	instr_dec_pkg::op_kind_t   last_kind;
	logic                      prev_done;

	instr_operand_decoder dut (
		.i_clk_sys    (i_clk_sys),
		.i_arst_n     (i_arst_n),
		.i_byte_valid (i_byte_valid),
		.i_byte       (i_byte),
		.i_size_bit   (i_size_bit),
		.i_mem_xfers  (i_mem_xfers),
		.i_string_dst (i_string_dst),
		.i_regs       (i_regs),
		.o_done       (o_done),
		.o_kind       (o_kind),
		.o_cycles     (o_cycles),
		.o_cycles_max (o_cycles_max),
		.o_op_valid   (o_op_valid),
		.o_operand    (o_operand),
		.o_lock       (o_lock)
	);

	// 250 MHz core clock
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one byte per cycle, changed on the falling edge
	task automatic put(input logic [7:0] b);
		@(negedge i_clk_sys);
		i_byte_valid = 1'b1;
		i_byte = b;
	endtask

	// idle bytes carry junk so a stale byte is never mistaken for data
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge i_clk_sys);
			i_byte_valid = 1'b0;
			i_byte = 8'($urandom);
		end
	endtask

	task automatic push_ctl(input instr_dec_pkg::op_kind_t k,
			input logic [7:0] c);
		exp_t e;
		e = '0;
		e.kind = k;
		e.cyc = c;
		e.cmax = c;
		exp_q.push_back(e);
	endtask

	// bounds check with one addressing byte and its displacement
	task automatic bounds(input logic [1:0] md, input logic [2:0] rm,
			input logic sz, input logic pf, input logic [1:0] ps);
		exp_t        e;
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [15:0] d;
		logic [15:0] a;
		instr_dec_pkg::addr_regs_t r;
		r = {$urandom, $urandom};
		lo = 8'($urandom);
		hi = 8'($urandom);
		i_regs = r;
		i_size_bit = sz;
		i_mem_xfers = 2'($urandom);
		i_string_dst = ($urandom % 4 == 0);
		d = (md == 2'h1) ? {{8{lo[7]}}, lo}
		  : (md == 2'h2) ? {hi, lo} : 16'h0;
		case (rm)
			3'h0: a = r.base_word + r.source_index_ptr + d;
			3'h1: a = r.base_word + r.dest_index_ptr + d;
			3'h2: a = r.frame_ptr + r.source_index_ptr + d;
			3'h3: a = r.frame_ptr + r.dest_index_ptr + d;
			3'h4: a = r.source_index_ptr + d;
			3'h5: a = r.dest_index_ptr + d;
			3'h6: a = r.frame_ptr + d;
			default: a = r.base_word + d;
		endcase
		if (md == 2'h0 && rm == 3'h6)
			a = {hi, lo};
		e = '0;
		e.kind = instr_dec_pkg::K_BOUND;
		e.cyc = 8'h21 + (sz ? 8'(4 * i_mem_xfers) : 8'h0);
		e.cmax = 8'h23 + (sz ? 8'(4 * i_mem_xfers) : 8'h0);
		e.has_op = 1'b1;
		e.op.is_reg = (md == 2'h3);
		e.op.reg_id = {sz, rm};
		e.op.effective_address = (md == 2'h3) ? 16'h0 : a;
		e.op.disp_bytes = (md == 2'h1) ? 2'h1 : (md == 2'h2) ? 2'h2 :
			(md == 2'h0 && rm == 3'h6) ? 2'h2 : 2'h0;
		if (i_string_dst)
			e.op.seg = instr_dec_pkg::SEG_EXTRA;
		else if (pf)
			e.op.seg = instr_dec_pkg::seg_t'(ps);
		else if (rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && md != 2'h0))
			e.op.seg = instr_dec_pkg::SEG_STACK;
		else
			e.op.seg = instr_dec_pkg::SEG_DATA;
		e.mask = '1;
		if (md == 2'h3)
			e.mask.seg = instr_dec_pkg::SEG_EXTRA;
		else
			e.mask.reg_id = 4'h0;
		exp_q.push_back(e);
		if (pf)
			put({3'b001, ps, 3'b110});
		put(8'h62);
		put({md, 3'($urandom), rm});
		if (e.op.disp_bytes != 2'h0)
			put(lo);
		if (e.op.disp_bytes == 2'h2)
			put(hi);
		idle(3);
	endtask

	// watcher: every completion takes the oldest note
	always @(negedge i_clk_sys) begin
		if (i_arst_n === 1'b1 && o_done === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(32'h1, 32'h0);
			end else begin
				exp_t e;
				e = exp_q.pop_front();
				chk(32'(o_kind), 32'(e.kind));
				chk(32'(o_cycles), 32'(e.cyc));
				chk(32'(o_cycles_max), 32'(e.cmax));
				chk(32'(o_op_valid), 32'(e.has_op));
				if (e.has_op)
					chk(32'(o_operand & e.mask), 32'(e.op & e.mask));
			end
			last_kind = o_kind;
		end else if (i_arst_n === 1'b1 && prev_done === 1'b1) begin
			// lock level is judged once the completion has settled
			chk(32'(o_lock),
			    32'(last_kind == instr_dec_pkg::K_LOCK));
		end
		prev_done = o_done;
	end

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		#40000;
		num_errors++;
		give_verdict();
	end

	initial begin
		i_arst_n = 1'b0;
		i_byte_valid = 1'b0;
		i_byte = 8'h00;
		i_size_bit = 1'b0;
		i_mem_xfers = 2'h0;
		i_string_dst = 1'b0;
		i_regs = '0;
		num_errors = 0;
		checks_done = 0;
		last_kind = instr_dec_pkg::K_NONE;
		prev_done = 1'b0;
		void'($urandom(32'hFB10));
		repeat (3) @(negedge i_clk_sys);
		chk(32'({o_done, o_kind, o_cycles, o_lock}), 32'h0);
		i_arst_n = 1'b1;

		// fixed-cost opcodes other than lock and no-operation, back to back
		push_ctl(instr_dec_pkg::K_CARRY_CLR, 8'h02);
		put(8'hF8);
		push_ctl(instr_dec_pkg::K_CARRY_FLP, 8'h02);
		put(8'hF5);
		push_ctl(instr_dec_pkg::K_CARRY_SET, 8'h02);
		put(8'hF9);
		push_ctl(instr_dec_pkg::K_DIR_CLR, 8'h02);
		put(8'hFC);
		push_ctl(instr_dec_pkg::K_DIR_SET, 8'h02);
		put(8'hFD);
		push_ctl(instr_dec_pkg::K_INTR_CLR, 8'h02);
		put(8'hFA);
		push_ctl(instr_dec_pkg::K_INTR_SET, 8'h02);
		put(8'hFB);
		push_ctl(instr_dec_pkg::K_HALT, 8'h02);
		put(8'hF4);
		push_ctl(instr_dec_pkg::K_INTR_RET, 8'h1C);
		put(8'hCF);
		push_ctl(instr_dec_pkg::K_SOFT_INTR, 8'h2F);
		put(8'hCD);
		put(8'($urandom));
		idle(3);
		$display("test control opcodes done");

		// lock stands until the next completion
		push_ctl(instr_dec_pkg::K_LOCK, 8'h02);
		put(8'hF0);
		idle(3);
		put(8'h37);
		push_ctl(instr_dec_pkg::K_NOP, 8'h03);
		put(8'h90);
		idle(3);
		$display("test lock and no-operation done");

		// mid-run reset must clear every result register
		i_arst_n = 1'b0;
		idle(2);
		chk(32'({o_done, o_kind, o_cycles, o_cycles_max, o_lock}), 32'h0);
		chk(32'({o_op_valid, o_operand}), 32'h0);
		i_arst_n = 1'b1;
		$display("test mid-run reset done");

		// every form and select, both sizes
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 4; m++) begin
				for (int r = 0; r < 8; r++) begin
					bounds(2'(m), 3'(r), 1'(s), 1'(m ^ r), 2'(r >> 1));
				end
			end
		end
		idle(4);
		$display("test bounds operands done");
		chk(32'(exp_q.size()), 32'h0);
		give_verdict();
	end
endmodule
